/* File: common/isw_link_if.sv */
// open-drain two-wire link joining the bus master and the switch device
`timescale 1ns/1ps
interface isw_link_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // pull-ups: a line is low only while some party drives a low
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport host (
    output scl_o,
    output scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input sda
  );

  modport dev (
    input scl,
    input sda,
    output d_sda_o,
    output d_sda_oe
  );
endinterface

/* File: common/isw_pkg.sv */
// shared constants and types for the two-wire switch-control link
// How it works
// - idle bus leaves both lines released high
// - data falling while clock high is start
// - data rising while clock high is stop
// - data held steady during clock high
// - one bit per clock pulse, sampled high
// - master starts only on an idle bus; isw_master starts on cmd_valid without sensing the lines
// - any number of bytes per transaction
// - eight bits msb first, then ack slot
// - byte sender releases data in ack slot
// - master gives ninth clock for ack
// - addressed device acks every received byte
// - reading master acks all but last byte
// - acker holds data low through ack high
// - master ends read by leaving ack high
// - after read nack device releases data line
// - write is start, address, data, stop
// - read returns control byte, master nacks
// - last address bit one reads, zero writes
// - several written bytes keep the last one
// - new enables apply after data ack
// - reset clears control byte and machine
package isw_pkg;

  localparam int BYTE_BITS = 8;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE = 4'h1;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic RW_READ = 1'b1;
  // arbitrary upper address nibble; straps supply the low three bits
  localparam logic [3:0] ADDR_HI_DEFAULT = 4'h5;
  localparam int STRAP_W = 3;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_STRAP0 = 2;
  localparam int PIN_W = 5;

  // master side timing: scl period is four quarters
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QUARTER_LAST = 8'(SCL_QUARTER_CYC - 1);
  localparam logic [7:0] TICK_ZERO = 8'h00;
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_ADDR_ACK = 3'b010,
    D_WR = 3'b011,
    D_WR_ACK = 3'b100,
    D_RD = 3'b101,
    D_RD_ACK = 3'b110,
    D_SKIP = 3'b111
  } isw_dev_st_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_START = 2'b01,
    M_BIT = 2'b10,
    M_STOP = 2'b11
  } isw_mst_st_t;

endpackage

/* File: rtl/isw_dev.sv */
// switch-control slave: link logic on link_clk, channel enables on clk
`timescale 1ns/1ps
module isw_dev #(
  parameter logic [3:0] ADDR_HI = isw_pkg::ADDR_HI_DEFAULT
) (
  // system side
  input wire logic clk,
  input wire logic srst,
  input wire logic rst_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  output logic [7:0] chan_en,
  // link side
  input wire logic link_clk,
  isw_link_if.dev bus
);

  // ---------------- clk domain: reset pin filter ----------------
  logic rstn_s1_ff;
  logic rstn_s2_ff;
  logic rstn_s3_ff;
  logic rstn_f_ff;
  logic dev_rst_ff;

  always_ff @(posedge clk) begin
    rstn_s1_ff <= rst_n;
    rstn_s2_ff <= rstn_s1_ff;
    rstn_s3_ff <= rstn_s2_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rstn_f_ff <= 1'b1;
    end else if (rstn_s2_ff == rstn_s3_ff) begin
      rstn_f_ff <= rstn_s3_ff;
    end
  end

  // power-on (srst) and the reset pin act alike
  always_ff @(posedge clk) begin
    dev_rst_ff <= srst | ~rstn_f_ff;
  end

  // ---------------- link domain: reset crossing ----------------
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic lrst;

  always_ff @(posedge link_clk) begin
    lrst_s1_ff <= dev_rst_ff;
    lrst_s2_ff <= lrst_s1_ff;
  end
  assign lrst = lrst_s2_ff;

  // ---------------- link domain: pin filters ----------------
  logic [isw_pkg::PIN_W-1:0] pin_in;
  logic [isw_pkg::PIN_W-1:0] pin_s1_ff;
  logic [isw_pkg::PIN_W-1:0] pin_s2_ff;
  logic [isw_pkg::PIN_W-1:0] pin_s3_ff;
  logic [isw_pkg::PIN_W-1:0] pin_f_ff;
  logic [isw_pkg::PIN_W-1:0] pin_p_ff;

  assign pin_in = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, bus.sda, bus.scl};

  always_ff @(posedge link_clk) begin
    pin_s1_ff <= pin_in;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
  end

  // a change counts only once two stages agree, which rejects short glitches
  genvar gi;
  generate
    for (gi = 0; gi < isw_pkg::PIN_W; gi++) begin : g_pin
      always_ff @(posedge link_clk) begin
        if (lrst) begin
          pin_f_ff[gi] <= 1'b1;
          pin_p_ff[gi] <= 1'b1;
        end else begin
          if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
            pin_f_ff[gi] <= pin_s3_ff[gi];
          end
          pin_p_ff[gi] <= pin_f_ff[gi];
        end
      end
    end
  endgenerate

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic ev_start;
  logic ev_stop;
  logic [isw_pkg::STRAP_W-1:0] strap;

  assign scl_f = pin_f_ff[isw_pkg::PIN_SCL];
  assign sda_f = pin_f_ff[isw_pkg::PIN_SDA];
  assign strap = pin_f_ff[isw_pkg::PIN_STRAP0 +: isw_pkg::STRAP_W];
  assign scl_rise = scl_f & ~pin_p_ff[isw_pkg::PIN_SCL];
  assign scl_fall = ~scl_f & pin_p_ff[isw_pkg::PIN_SCL];
  // sda moving while scl stays high is a control condition, never data
  assign ev_start = scl_f & pin_p_ff[isw_pkg::PIN_SCL] & ~sda_f & pin_p_ff[isw_pkg::PIN_SDA];
  assign ev_stop = scl_f & pin_p_ff[isw_pkg::PIN_SCL] & sda_f & ~pin_p_ff[isw_pkg::PIN_SDA];

  // ---------------- link domain: transaction machine ----------------
  isw_pkg::isw_dev_st_t st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] ctrl_ff;
  logic rw_ff;
  logic nak_ff;
  logic tog_ff;
  logic sda_oe_ff;
  logic addr_hit;
  logic rx_state;
  logic ev_fall;
  logic ev_rise;

  assign ev_fall = scl_fall & ~ev_start & ~ev_stop;
  assign ev_rise = scl_rise & ~ev_start & ~ev_stop;
  assign rx_state = (st_ff == isw_pkg::D_ADDR) | (st_ff == isw_pkg::D_WR);
  assign addr_hit = (sh_ff[7:1] == {ADDR_HI, strap});

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st_ff <= isw_pkg::D_IDLE;
      cnt_ff <= isw_pkg::BIT_CNT_ZERO;
      rw_ff <= 1'b0;
      nak_ff <= 1'b1;
    end else if (ev_start) begin
      st_ff <= isw_pkg::D_ADDR;
      cnt_ff <= isw_pkg::BIT_CNT_ZERO;
    end else if (ev_stop) begin
      st_ff <= isw_pkg::D_IDLE;
    end else if (ev_rise && rx_state && cnt_ff != isw_pkg::BIT_CNT_FULL) begin
      cnt_ff <= cnt_ff + isw_pkg::BIT_CNT_ONE;
    end else if (ev_rise && st_ff == isw_pkg::D_RD_ACK) begin
      nak_ff <= sda_f;
    end else if (ev_fall) begin
      unique case (st_ff)
        isw_pkg::D_ADDR: begin
          if (cnt_ff == isw_pkg::BIT_CNT_FULL) begin
            rw_ff <= sh_ff[0];
            st_ff <= addr_hit ? isw_pkg::D_ADDR_ACK : isw_pkg::D_SKIP;
          end
        end
        isw_pkg::D_ADDR_ACK: begin
          cnt_ff <= isw_pkg::BIT_CNT_ZERO;
          st_ff <= (rw_ff == isw_pkg::RW_READ) ? isw_pkg::D_RD : isw_pkg::D_WR;
        end
        isw_pkg::D_WR: begin
          if (cnt_ff == isw_pkg::BIT_CNT_FULL) begin
            st_ff <= isw_pkg::D_WR_ACK;
          end
        end
        isw_pkg::D_WR_ACK: begin
          cnt_ff <= isw_pkg::BIT_CNT_ZERO;
          st_ff <= isw_pkg::D_WR;
        end
        isw_pkg::D_RD: begin
          if (cnt_ff == isw_pkg::BIT_CNT_LAST) begin
            st_ff <= isw_pkg::D_RD_ACK;
          end else begin
            cnt_ff <= cnt_ff + isw_pkg::BIT_CNT_ONE;
          end
        end
        isw_pkg::D_RD_ACK: begin
          cnt_ff <= isw_pkg::BIT_CNT_ZERO;
          st_ff <= nak_ff ? isw_pkg::D_SKIP : isw_pkg::D_RD;
        end
        isw_pkg::D_IDLE, isw_pkg::D_SKIP: begin
          st_ff <= st_ff;
        end
      endcase
    end
  end

  // shift register: msb first in both directions
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      sh_ff <= isw_pkg::CTRL_RESET;
    end else if (ev_rise && rx_state && cnt_ff != isw_pkg::BIT_CNT_FULL) begin
      sh_ff <= {sh_ff[6:0], sda_f};
    end else if (ev_fall && st_ff == isw_pkg::D_ADDR_ACK && rw_ff == isw_pkg::RW_READ) begin
      sh_ff <= ctrl_ff;
    end else if (ev_fall && st_ff == isw_pkg::D_RD_ACK) begin
      sh_ff <= ctrl_ff;
    end else if (ev_fall && st_ff == isw_pkg::D_RD && cnt_ff != isw_pkg::BIT_CNT_LAST) begin
      sh_ff <= {sh_ff[6:0], 1'b0};
    end
  end

  // control byte commits at the fall that ends our ack; a later byte overwrites
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      ctrl_ff <= isw_pkg::CTRL_RESET;
      tog_ff <= 1'b0;
    end else if (ev_fall && st_ff == isw_pkg::D_WR_ACK) begin
      ctrl_ff <= sh_ff;
      tog_ff <= ~tog_ff;
    end
  end

  // data pin: low for our acks and for zero bits we send, released otherwise
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      sda_oe_ff <= 1'b0;
    end else if (ev_start || ev_stop) begin
      sda_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= (st_ff == isw_pkg::D_ADDR_ACK) | (st_ff == isw_pkg::D_WR_ACK)
                 | ((st_ff == isw_pkg::D_RD) & ~sh_ff[7]);
    end
  end

  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = sda_oe_ff;

  // ---------------- clk domain: enable update by toggle ----------------
  // ctrl_ff holds steady for a whole byte time, far longer than the toggle crossing
  logic tg_s1_ff;
  logic tg_s2_ff;
  logic tg_s3_ff;
  logic [7:0] chan_en_ff;

  always_ff @(posedge clk) begin
    tg_s1_ff <= tog_ff;
    tg_s2_ff <= tg_s1_ff;
    tg_s3_ff <= tg_s2_ff;
  end

  always_ff @(posedge clk) begin
    if (dev_rst_ff || srst) begin
      chan_en_ff <= isw_pkg::CTRL_RESET;
    end else if (tg_s2_ff != tg_s3_ff) begin
      chan_en_ff <= ctrl_ff;
    end
  end

  assign chan_en = chan_en_ff;

endmodule

/* File: rtl/isw_master.sv */
// bus master: makes scl by a divider and runs one-byte write or read transfers
`timescale 1ns/1ps
module isw_master (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // response
  output logic rsp_valid,
  output logic rsp_addr_ack,
  output logic [7:0] rsp_data,
  // link
  isw_link_if.host bus
);

  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_s3_ff;
  logic sda_f_ff;

  always_ff @(posedge clk) begin
    sda_s1_ff <= bus.sda;
    sda_s2_ff <= sda_s1_ff;
    sda_s3_ff <= sda_s2_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sda_f_ff <= 1'b1;
    end else if (sda_s2_ff == sda_s3_ff) begin
      sda_f_ff <= sda_s3_ff;
    end
  end

  isw_pkg::isw_mst_st_t st_ff;
  logic [7:0] tick_ff;
  logic [1:0] q_ff;
  logic [3:0] bit_ff;
  logic byte1_ff;
  logic rd_ff;
  logic nak_ff;
  logic [7:0] sh_ff;
  logic [7:0] data_ff;
  logic [7:0] rx_ff;
  logic ack_ok_ff;
  logic rsp_valid_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic tick;
  logic in_data;
  logic sender;

  assign tick = (tick_ff == isw_pkg::QUARTER_LAST);
  assign in_data = (bit_ff != isw_pkg::BIT_CNT_FULL);
  // we send the address byte and a write data byte; read data is the device's
  assign sender = ~byte1_ff | ~rd_ff;
  assign cmd_ready = (st_ff == isw_pkg::M_IDLE);

  always_ff @(posedge clk) begin
    if (srst || st_ff == isw_pkg::M_IDLE || tick) begin
      tick_ff <= isw_pkg::TICK_ZERO;
    end else begin
      tick_ff <= tick_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= isw_pkg::M_IDLE;
      q_ff <= isw_pkg::Q0;
      bit_ff <= isw_pkg::BIT_CNT_ZERO;
      byte1_ff <= 1'b0;
      rd_ff <= 1'b0;
      nak_ff <= 1'b1;
      sh_ff <= isw_pkg::CTRL_RESET;
      data_ff <= isw_pkg::CTRL_RESET;
      rx_ff <= isw_pkg::CTRL_RESET;
      ack_ok_ff <= 1'b0;
    end else if (st_ff == isw_pkg::M_IDLE) begin
      if (cmd_valid) begin
        st_ff <= isw_pkg::M_START;
        q_ff <= isw_pkg::Q0;
        rd_ff <= cmd_read;
        sh_ff <= {cmd_addr, cmd_read};
        data_ff <= cmd_data;
        byte1_ff <= 1'b0;
        bit_ff <= isw_pkg::BIT_CNT_ZERO;
        ack_ok_ff <= 1'b0;
      end
    end else if (tick) begin
      q_ff <= q_ff + 2'h1;
      if (st_ff == isw_pkg::M_BIT && q_ff == isw_pkg::Q2) begin
        if (in_data) begin
          rx_ff <= {rx_ff[6:0], sda_f_ff};
        end else begin
          nak_ff <= sda_f_ff;
        end
      end
      if (q_ff == isw_pkg::Q3) begin
        unique case (st_ff)
          isw_pkg::M_START: begin
            st_ff <= isw_pkg::M_BIT;
          end
          isw_pkg::M_BIT: begin
            if (in_data) begin
              bit_ff <= bit_ff + isw_pkg::BIT_CNT_ONE;
              sh_ff <= {sh_ff[6:0], 1'b0};
            end else if (!byte1_ff && !nak_ff) begin
              ack_ok_ff <= 1'b1;
              byte1_ff <= 1'b1;
              bit_ff <= isw_pkg::BIT_CNT_ZERO;
              sh_ff <= data_ff;
            end else begin
              st_ff <= isw_pkg::M_STOP;
            end
          end
          isw_pkg::M_STOP: begin
            st_ff <= isw_pkg::M_IDLE;
          end
          isw_pkg::M_IDLE: begin
            st_ff <= isw_pkg::M_IDLE;
          end
        endcase
      end
    end
  end

  // quarters: start drops sda then scl; a bit is low,high,high,low; stop lifts sda last
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        isw_pkg::M_IDLE: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
        end
        isw_pkg::M_START: begin
          scl_oe_ff <= (q_ff == isw_pkg::Q2) | (q_ff == isw_pkg::Q3);
          sda_oe_ff <= (q_ff != isw_pkg::Q0);
        end
        isw_pkg::M_BIT: begin
          scl_oe_ff <= (q_ff == isw_pkg::Q0) | (q_ff == isw_pkg::Q3);
          // ack slot stays released: we never ack a read byte, ending the read
          sda_oe_ff <= in_data & sender & ~sh_ff[7];
        end
        isw_pkg::M_STOP: begin
          scl_oe_ff <= (q_ff == isw_pkg::Q0);
          sda_oe_ff <= (q_ff == isw_pkg::Q0) | (q_ff == isw_pkg::Q1);
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (st_ff == isw_pkg::M_STOP) & tick & (q_ff == isw_pkg::Q3);
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_ff;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_addr_ack = ack_ok_ff;
  assign rsp_data = rx_ff;

endmodule

/* File: testbench/isw_link_chk.sv */
// assertions on the two-wire link between the bus master and the switch device
`timescale 1ns/1ps
module isw_link_chk (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link drivers and resolved lines
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_ff, sda_q_ff, busy_ff, rw_ff, acked_ff;
  logic [3:0] idx_ff;
  logic [1:0] byte_ff;
  logic rise, start_det, stop_det, ack_rise;
  assign rise = scl & ~scl_q_ff;
  assign start_det = scl & scl_q_ff & sda_q_ff & ~sda;
  assign stop_det = scl & scl_q_ff & ~sda_q_ff & sda;
  // idx counts pulses within a nine-pulse unit, so index 8 is the ack slot
  assign ack_rise = rise & (idx_ff == 4'h8);
  always_ff @(posedge clk) begin
    scl_q_ff <= srst | scl;
    sda_q_ff <= srst | sda;
  end
  always_ff @(posedge clk) begin
    if (srst | stop_det) busy_ff <= 1'b0;
    else if (start_det) busy_ff <= 1'b1;
  end
  always_ff @(posedge clk) begin
    // the stop's own clock pulse leaves idx at one; clear it for the next frame
    if (srst | start_det | stop_det) idx_ff <= 4'h0;
    else if (rise) idx_ff <= (idx_ff == 4'h8) ? 4'h0 : idx_ff + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (srst | start_det) byte_ff <= 2'h0;
    else if (ack_rise && byte_ff != 2'h3) byte_ff <= byte_ff + 2'h1;
  end
  always_ff @(posedge clk) begin
    if (rise && idx_ff == 4'h7 && byte_ff == 2'h0) rw_ff <= sda;
    if (ack_rise && byte_ff == 2'h0) acked_ff <= ~sda;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_idle;
    !busy_ff |-> !scl_oe && !d_sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("link driven while idle");
  property p_dev_scl_low;
    $changed(d_sda_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("device sda moved in clock high");
  property p_mst_ctrl;
    scl && scl_q_ff && $changed(m_sda_oe)
      |-> (start_det && idx_ff == 4'h0) || (stop_det && idx_ff == 4'h1);
  endproperty
  a_mst_ctrl: assert property (p_mst_ctrl) else $error("master sda moved inside a unit");
  property p_rel_m;
    ack_rise && (byte_ff == 2'h0 || !rw_ff) |-> !m_sda_oe;
  endproperty
  a_rel_m: assert property (p_rel_m) else $error("master holds sda in ack slot");
  property p_ack_hold;
    ack_rise && d_sda_oe |-> !sda [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not held low");
  property p_wr_ack;
    ack_rise && byte_ff != 2'h0 && !rw_ff && acked_ff |-> !sda && d_sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
  property p_rd_nack;
    ack_rise && byte_ff != 2'h0 && rw_ff |-> sda && !d_sda_oe;
  endproperty
  a_rd_nack: assert property (p_rd_nack) else $error("read ack slot not high");
  property p_release;
    ack_rise && byte_ff != 2'h0 && rw_ff && sda |-> ##60 !d_sda_oe [*8];
  endproperty
  a_release: assert property (p_release) else $error("device drives after nack");
  property p_units;
    stop_det |-> idx_ff == 4'h1 && byte_ff != 2'h0;
  endproperty
  a_units: assert property (p_units) else $error("stop inside a unit");
  property p_drive_low;
    !scl_o && !m_sda_o && !d_sda_o && (!scl_oe || !scl)
      && (!m_sda_oe || !sda) && (!d_sda_oe || !sda);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("driven line not low");
  c_write: cover property (ack_rise && byte_ff == 2'h1 && !rw_ff && !sda);
  c_read: cover property (ack_rise && byte_ff == 2'h1 && rw_ff && sda);
  c_nack: cover property (ack_rise && byte_ff == 2'h0 && sda);
endmodule

/* File: testbench/test_i2c_switch_control_slave.sv */
// bench: design master and device on one link, a bit-banged driver on a second
`timescale 1ns/1ps
module test_i2c_switch_control_slave;
  logic clk, link_clk, srst, rst_n, cmd_valid, cmd_read, b_scl, b_sda, ak, s;
  logic cmd_ready, rsp_valid, rsp_addr_ack;
  logic [6:0] cmd_addr, old;
  logic [7:0] cmd_data, rsp_data, chan_en, chan_en_b, ctrl;
  logic [2:0] strap;
  logic [17:0] bits;
  logic [7:0] vals [3] = '{8'h5A, 8'hFF, 8'h81};
  int rises, starts, stops, bad_count, compares;
  isw_link_if lk ();
  isw_link_if lk2 ();
  assign lk2.scl_o = 1'b0;
  assign lk2.scl_oe = ~b_scl;
  assign lk2.m_sda_o = 1'b0;
  assign lk2.m_sda_oe = ~b_sda;
  isw_master isw_master_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_addr_ack(rsp_addr_ack), .rsp_data(rsp_data), .bus(lk.host));
  isw_dev isw_dev_inst (.clk(clk), .srst(srst), .rst_n(rst_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .chan_en(chan_en),
    .link_clk(link_clk), .bus(lk.dev));
  isw_dev isw_dev_b_inst (.clk(clk), .srst(srst), .rst_n(rst_n), .addr_strap_bit0(1'b0),
    .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b0), .chan_en(chan_en_b),
    .link_clk(link_clk), .bus(lk2.dev));
  isw_link_chk isw_link_chk_inst (.clk(clk), .srst(srst), .scl_o(lk.scl_o),
    .scl_oe(lk.scl_oe), .m_sda_o(lk.m_sda_o), .m_sda_oe(lk.m_sda_oe), .d_sda_o(lk.d_sda_o),
    .d_sda_oe(lk.d_sda_oe), .scl(lk.scl), .sda(lk.sda));
  always #50 clk = ~clk;
  // odd offset keeps the link clock edges off the system clock edges
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // bits are taken at the fall, so the stop's lone clock pulse adds none
  always @(negedge lk.scl) bits <= {bits[16:0], lk.sda};
  always @(posedge lk.scl) rises <= rises + 1;
  always @(negedge lk.sda) if (lk.scl === 1'b1) starts <= starts + 1;
  always @(posedge lk.sda) if (lk.scl === 1'b1) stops <= stops + 1;
  function logic [6:0] own_addr();
    return {isw_pkg::ADDR_HI_DEFAULT, strap};
  endfunction
  task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task cmd(input logic rd, input logic [6:0] a, input logic [7:0] d, input logic ack);
    logic [7:0] snap;
    logic [17:0] exp_bits;
    int n;
    snap = chan_en;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_data = d;
    rises = 0;
    starts = 0;
    stops = 0;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("busy", 18'h0_0000, cmd_ready);
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
      // last value before the data ack pulse rises
      if (rises == 17) snap = chan_en;
    end
    chk("rsp_in_time", 1, n < 3000);
    chk("ready", 1, cmd_ready);
    // nine pulses a byte, plus the stop's own pulse
    chk("pulses", ack ? 18'h0_0013 : 18'h0_000A, rises[17:0]);
    exp_bits = ack ? {a, rd, 1'b0, rd ? ctrl : d, rd} : {9'h000, a, rd, 1'b1};
    chk("wire_bits", exp_bits, ack ? bits : {9'h000, bits[8:0]});
    chk("frames", 18'h0_0201, {1'b0, starts[7:0], 1'b0, stops[7:0]});
    chk("idle_lines", 2'b11, {lk.scl, lk.sda});
    chk("addr_ack", ack, rsp_addr_ack);
    chk("chan_before_ack", ctrl, snap);
    if (rd && ack) chk("rsp_data", ctrl, rsp_data);
    if (!rd && ack) ctrl = d;
    chk("chan_en", ctrl, chan_en);
  endtask
  task q(input int n);
    repeat (n * isw_pkg::SCL_QUARTER_CYC) @(negedge clk);
  endtask
  task bb(input logic v);
    b_sda = v;
    q(1);
    b_scl = 1'b1;
    q(1);
    s = lk2.sda;
    q(1);
    b_scl = 1'b0;
    q(1);
  endtask
  task bstart();
    b_sda = 1'b1;
    q(1);
    b_scl = 1'b1;
    q(1);
    b_sda = 1'b0;
    q(1);
    b_scl = 1'b0;
    q(1);
  endtask
  task bstop();
    b_sda = 1'b0;
    q(1);
    b_scl = 1'b1;
    q(1);
    b_sda = 1'b1;
    q(1);
  endtask
  task bbyte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bb(v[i]);
    bb(1'b1);
    ak = ~s;
  endtask
  initial begin
    #6000000;
    bad_count++;
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    rst_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 8'h00;
    b_scl = 1'b1;
    b_sda = 1'b1;
    strap = 3'b101;
    ctrl = 8'h00;
    bits = 18'h0_0000;
    bad_count = 0;
    compares = 0;
    rises = 0;
    starts = 0;
    stops = 0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    repeat (5) @(negedge clk);
    chk("chan_reset", 8'h00, chan_en);
    foreach (vals[i]) begin
      cmd(1'b0, own_addr(), vals[i], 1'b1);
      cmd(1'b1, own_addr(), 8'h00, 1'b1);
    end
    // straps are filtered, so give them time before the next frame
    old = own_addr();
    strap = 3'b011;
    repeat (10) @(negedge clk);
    cmd(1'b0, old, 8'h7E, 1'b0);
    cmd(1'b1, own_addr(), 8'h00, 1'b1);
    bstart();
    bbyte({isw_pkg::ADDR_HI_DEFAULT, 3'b000, 1'b0});
    chk("b_addr_ack", 1, ak);
    bbyte(8'h3C);
    chk("b_first_ack", 1, ak);
    bbyte(8'hA5);
    chk("b_second_ack", 1, ak);
    bstop();
    q(1);
    chk("b_last_kept", 8'hA5, chan_en_b);
    bstart();
    bbyte({isw_pkg::ADDR_HI_DEFAULT, 3'b000, 1'b0});
    for (int i = 0; i < 4; i++) bb(1'b0);
    bstart();
    bbyte({isw_pkg::ADDR_HI_DEFAULT, 3'b000, 1'b0});
    chk("b_restart_ack", 1, ak);
    bstop();
    q(1);
    chk("b_ctrl_kept", 8'hA5, chan_en_b);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("rst_chan", 8'h00, chan_en);
    rst_n = 1'b1;
    ctrl = 8'h00;
    repeat (10) @(negedge clk);
    cmd(1'b1, own_addr(), 8'h00, 1'b1);
    end_of_test();
  end
endmodule
